// [lsx_defs.svh]
`ifndef LSX_DEFS_SVH
`define LSX_DEFS_SVH

`define LSX_RCTL_LINK_DATA    4'h3
`define LSX_RCTL_INFO_USOL    4'h2
`define LSX_RCTL_INFO_SOL     4'h3
`define LSX_RJT_CMD_WORD      32'h01000000
`define LSX_RSN_NOT_SUPP      8'h0b
`define LSX_EXP_NONE          8'h00
`define LSX_EXP_NO_RSRC       8'h29
`define LSX_EXP_NO_DATA       8'h2a
`define LSX_EXP_REQ_UNSUPP    8'h2c
`define LSX_EXP_BAD_LEN       8'h2d
`define LSX_EXP_BAD_NAME      8'h44
`define LSX_EXP_EXT_UNSUPP    8'h46
`define LSX_EXP_AUTH_REQ      8'h48
`define LSX_EXP_SCAN_BAD      8'h50
`define LSX_EXP_SCAN_UNSUPP   8'h51
`define LSX_EXP_PRLI_NORES    8'h52
`define LSX_EXP_MAC_MODE      8'h60
`define LSX_EXP_MAC_FORM      8'h61
`define LSX_EXP_NOT_NEIGH     8'h62

`endif

// [lsx_peer.sv]
`timescale 1ns/1ps
module lsx_peer
(
	input  wire logic mclk,
	output logic      rx_valid = 0,
	output logic      rx_sof,
	output logic      rx_eof,
	output logic [31:0] rx_hdr0 = 0,
	output logic [7:0]  rx_type = 0,
	output logic      rx_seq_init = 0,
	output logic      tx_ready = 0
);
	int seed = 32'h1986;
	assign rx_sof = rx_valid;
	assign rx_eof = rx_valid;
	always @(posedge mclk)
		tx_ready <= #1 1'($random(seed));
	// Released lines show the inverse so a stale header is never reused.
	task send(input logic [7:0] r, t, input logic init);
		@(posedge mclk);
		#1;
		rx_hdr0 = {r, 24'($random(seed))};
		rx_type = t;
		rx_seq_init = init;
		rx_valid = 1;
		@(posedge mclk);
		#1;
		rx_valid = 0;
		rx_hdr0 = ~rx_hdr0;
		rx_type = ~rx_type;
		rx_seq_init = ~init;
	endtask
endmodule

// [lsx_pkg.sv]
package lsx_pkg;

	// Cause that the request checker reports for a reject.
	typedef enum logic [3:0] {
		LSX_CAUSE_NONE      = 4'h0,
		LSX_CAUSE_NO_RSRC   = 4'h1,
		LSX_CAUSE_NO_DATA   = 4'h2,
		LSX_CAUSE_UNSUPP    = 4'h3,
		LSX_CAUSE_BAD_LEN   = 4'h4,
		LSX_CAUSE_BAD_NAME  = 4'h5,
		LSX_CAUSE_EXT       = 4'h6,
		LSX_CAUSE_AUTH      = 4'h7,
		LSX_CAUSE_SCAN_BAD  = 4'h8,
		LSX_CAUSE_SCAN_NONE = 4'h9,
		LSX_CAUSE_PRLI_NORES = 4'ha,
		LSX_CAUSE_MAC_MODE  = 4'hb,
		LSX_CAUSE_MAC_FORM  = 4'hc,
		LSX_CAUSE_NOT_NEIGH = 4'hd
	} lsx_cause_t;

	typedef enum logic [3:0] {
		LSX_IDLE  = 4'b0001,
		LSX_RECV  = 4'b0010,
		LSX_WAIT  = 4'b0100,
		LSX_REPLY = 4'b1000
	} lsx_state_t;

endpackage

// [lsx_responder.sv]
`timescale 1ns/1ps
`include "lsx_defs.svh"

module lsx_responder
	import lsx_pkg::*;
#(
	parameter logic [7:0] FC4_TYPE = 8'h08
)
(
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic        rx_valid,
	input  wire logic        rx_sof,
	input  wire logic        rx_eof,
	input  wire logic [31:0] rx_hdr0,
	input  wire logic [7:0]  rx_type,
	input  wire logic        rx_seq_init,
	input  wire logic        app_done,
	input  wire logic        app_reply,
	input  wire logic        app_reject,
	input  wire logic [3:0]  app_cause,
	input  wire logic        tx_ready,
	output logic             req_start,
	output logic             proto_err,
	output logic             tx_valid,
	output logic             tx_sof,
	output logic             tx_eof,
	output logic [31:0]      tx_hdr0,
	output logic [7:0]       tx_type,
	output logic [31:0]      tx_word,
	output logic             busy
);

	lsx_state_t state_q;
	logic       is_req;
	logic       rjt_q;
	logic [1:0] wcnt_q;
	logic [7:0] exp_q;
	logic [7:0] exp_d;
	logic       tx_fire;
	logic       req_sof;
	logic       seq_bad;
	logic [31:0] sol_hdr;
	logic [31:0] rsn_word;

	// A request frame: link data, unsolicited control, our TYPE.
	assign is_req = rx_hdr0[31:28] == `LSX_RCTL_LINK_DATA &&
			rx_hdr0[27:24] == `LSX_RCTL_INFO_USOL &&
			rx_type == FC4_TYPE;
	assign tx_fire = tx_valid && tx_ready;
	assign req_sof = rx_valid && rx_sof && is_req;

	// A sequence that ends without passing initiative leaves the exchange
	// with no one allowed to reply, so it is flagged and dropped.
	assign seq_bad = (state_q == LSX_RECV && rx_valid &&
			(rx_sof || (rx_eof && !rx_seq_init))) ||
			(state_q == LSX_IDLE && req_sof && rx_eof && !rx_seq_init);

	// Reply header word: link data with solicited control.
	assign sol_hdr = {`LSX_RCTL_LINK_DATA, `LSX_RCTL_INFO_SOL,
			24'h000000};
	// Second reject word: reason code, then the latched explanation.
	assign rsn_word = {8'h00, `LSX_RSN_NOT_SUPP, exp_q, 8'h00};
	assign busy = state_q != LSX_IDLE;

	always_comb
	begin
		unique case (app_cause)
		LSX_CAUSE_NO_RSRC:    exp_d = `LSX_EXP_NO_RSRC;
		LSX_CAUSE_BAD_LEN:    exp_d = `LSX_EXP_BAD_LEN;
		LSX_CAUSE_NO_DATA:    exp_d = `LSX_EXP_NO_DATA;
		LSX_CAUSE_UNSUPP:     exp_d = `LSX_EXP_REQ_UNSUPP;
		LSX_CAUSE_BAD_NAME:   exp_d = `LSX_EXP_BAD_NAME;
		LSX_CAUSE_EXT:        exp_d = `LSX_EXP_EXT_UNSUPP;
		LSX_CAUSE_AUTH:       exp_d = `LSX_EXP_AUTH_REQ;
		LSX_CAUSE_SCAN_BAD:   exp_d = `LSX_EXP_SCAN_BAD;
		LSX_CAUSE_SCAN_NONE:  exp_d = `LSX_EXP_SCAN_UNSUPP;
		LSX_CAUSE_PRLI_NORES: exp_d = `LSX_EXP_PRLI_NORES;
		LSX_CAUSE_MAC_MODE:   exp_d = `LSX_EXP_MAC_MODE;
		LSX_CAUSE_MAC_FORM:   exp_d = `LSX_EXP_MAC_FORM;
		LSX_CAUSE_NOT_NEIGH:  exp_d = `LSX_EXP_NOT_NEIGH;
		default:              exp_d = `LSX_EXP_NONE;
		endcase
	end

	// Exchange sequencing: one request sequence, then initiative, then reply if the application accepts or rejects.
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			state_q <= LSX_IDLE;
		else
		begin
			unique case (state_q)
			LSX_IDLE:
				if (req_sof)
				begin
					// A one-frame request without initiative is dropped here
					// rather than left waiting for an end that never comes.
					if (!rx_eof)
						state_q <= LSX_RECV;
					else if (rx_seq_init)
						state_q <= LSX_WAIT;
				end
			LSX_RECV:
				if (rx_valid && rx_eof)
					state_q <= rx_seq_init ? LSX_WAIT : LSX_IDLE;
			LSX_WAIT:
				if (app_done)
					state_q <= (app_reply || app_reject) ? LSX_REPLY
						: LSX_IDLE;
			LSX_REPLY:
				if (tx_fire && tx_eof)
					state_q <= LSX_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			req_start <= 1'b0;
			proto_err <= 1'b0;
		end
		else
		begin
			req_start <= state_q == LSX_IDLE && req_sof;
			proto_err <= seq_bad;
		end
	end

	// The explanation for app_cause is latched each time the application finishes in WAIT.
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			rjt_q <= 1'b0;
			exp_q <= `LSX_EXP_NONE;
		end
		else if (state_q == LSX_WAIT && app_done)
		begin
			rjt_q <= app_reject;
			exp_q <= exp_d;
		end
	end

	// Reply sequence: accept is one frame; a reject carries two words.
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			wcnt_q <= 2'd0;
		else if (state_q != LSX_REPLY)
			wcnt_q <= 2'd0;
		else if (tx_fire)
			wcnt_q <= wcnt_q + 2'd1;
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			tx_valid <= 1'b0;
			tx_sof   <= 1'b0;
			tx_eof   <= 1'b0;
			tx_hdr0  <= 32'h0;
			tx_type  <= 8'h0;
			tx_word  <= 32'h0;
		end
		else if (state_q == LSX_REPLY && !(tx_fire && tx_eof))
		begin
			tx_valid <= 1'b1;
			tx_hdr0  <= sol_hdr;
			tx_type  <= FC4_TYPE;
			tx_sof   <= (wcnt_q == 2'd0 && !tx_fire);
			tx_eof   <= !rjt_q || (wcnt_q == 2'd0 && tx_fire) ||
				wcnt_q == 2'd1;
			if (!rjt_q || (wcnt_q == 2'd0 && !tx_fire))
				tx_word <= rjt_q ? `LSX_RJT_CMD_WORD : 32'h0;
			else
				tx_word <= rsn_word;
		end
		else
		begin
			tx_valid <= 1'b0;
			tx_sof   <= 1'b0;
			tx_eof   <= 1'b0;
		end
	end

	// A zero TYPE names no device data protocol, so requests could never
	// be told apart from idle headers.
	generate
		if (FC4_TYPE == 8'h00)
		begin
			$error("FC4_TYPE zero is not a device data TYPE");
		end
	endgenerate

endmodule

// [lsx_responder_asserts.sv]
`timescale 1ns/1ps
module lsx_responder_asserts
#(
	parameter logic [7:0] FC4_TYPE = 8'h08
)
(
	input wire logic        mclk,
	input wire logic        rst_n,
	input wire logic        app_done,
	input wire logic        app_reject,
	input wire logic        tx_ready,
	input wire logic        tx_valid,
	input wire logic        tx_sof,
	input wire logic        tx_eof,
	input wire logic [31:0] tx_hdr0,
	input wire logic [7:0]  tx_type,
	input wire logic [31:0] tx_word
);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	route_bits_a:
	assert property (tx_valid |-> tx_hdr0[31:28] == 4'h3) else $error("route");
	sol_ctl_a:
	assert property (tx_valid |-> tx_hdr0[27:24] == 4'h3) else $error("cat");
	type_match_a:
	assert property (tx_valid |-> tx_type == FC4_TYPE) else $error("type");
	rjt_cmd_a:
	assert property (tx_valid && tx_sof && !tx_eof |-> tx_word == 32'h01000000)
		else $error("cmd word");
	rsn_code_a:
	assert property (tx_valid && tx_eof && !tx_sof |-> tx_word[23:16] == 8'h0b)
		else $error("reason");
	word_hold_a:
	assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_word))
		else $error("hold");
	reply_lat_a:
	assert property (app_done && app_reject |-> ##2 tx_valid && tx_sof)
		else $error("latency");
	rjt_end_a:
	assert property (tx_valid && tx_sof && !tx_eof && tx_ready |=> tx_eof)
		else $error("second word");
	cover property (tx_valid && tx_sof && tx_eof);
	cover property (tx_valid && !tx_ready);
	cover property (app_done && app_reject);
endmodule
bind lsx_responder lsx_responder_asserts #(.FC4_TYPE(FC4_TYPE)) chk_u (.mclk,
	.rst_n, .app_done, .app_reject, .tx_ready, .tx_valid, .tx_sof, .tx_eof,
	.tx_hdr0, .tx_type, .tx_word);

// [test_fc4_link_service_exchange.sv]
`timescale 1ns/1ps
module test_fc4_link_service_exchange;
	logic        mclk = 0;
	logic        rst_n = 0;
	logic        app_done = 0;
	logic        app_reply = 0;
	logic        app_reject = 0;
	logic [3:0]  app_cause = 0;
	logic        rx_valid, rx_sof, rx_eof, rx_seq_init, tx_ready, busy;
	logic        req_start, proto_err, tx_valid, tx_sof, tx_eof;
	logic [31:0] rx_hdr0, tx_hdr0, tx_word;
	logic [7:0]  rx_type, tx_type;
	logic [31:0] exp_q[$];
	logic [7:0]  exp_tab[14] = '{8'h00, 8'h29, 8'h2a, 8'h2c, 8'h2d, 8'h44,
		8'h46, 8'h48, 8'h50, 8'h51, 8'h52, 8'h60, 8'h61, 8'h62};
	int          error_cnt = 0;
	int          total_checks = 0;
	int          n;
	always #10 mclk = ~mclk;
	lsx_peer peer_u (.mclk, .rx_valid, .rx_sof, .rx_eof, .rx_hdr0, .rx_type,
		.rx_seq_init, .tx_ready);
	lsx_responder dut_u (.mclk, .rst_n, .rx_valid, .rx_sof, .rx_eof, .rx_hdr0,
		.rx_type, .rx_seq_init, .app_done, .app_reply, .app_reject, .app_cause,
		.tx_ready, .req_start, .proto_err, .tx_valid, .tx_sof, .tx_eof,
		.tx_hdr0, .tx_type, .tx_word, .busy);
	task chk(input logic [31:0] got, exp, input string m);
		total_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("wrong value %0t %s", $time, m);
		end
	endtask
	task test_done;
		$display("errors %0d checks %0d", error_cnt, total_checks);
		if (error_cnt == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task exch(input logic [7:0] r, t, input logic init, input int rsp, c);
		logic s, e;
		s = 0;
		e = 0;
		peer_u.send(r, t, init);
		repeat (4)
		begin
			s |= req_start;
			e |= proto_err;
			@(posedge mclk);
			#1;
		end
		chk(s, r == 8'h32 && t == 8'h08, "taken");
		chk(e, s && !init, "initiative");
		if (s && init)
		begin
			if (rsp == 2)
				exp_q = '{32'h01000000, {16'h000b, exp_tab[c], 8'h00}};
			if (rsp == 1)
				exp_q = '{32'h0};
			app_done = 1;
			app_reply = rsp == 1;
			app_reject = rsp == 2;
			app_cause = 4'(c);
			@(posedge mclk);
			#1;
			app_done = 0;
		end
		for (n = 0; busy !== 1'b0 && n < 40; n++)
			@(posedge mclk);
		if (n == 40)
		begin
			error_cnt++;
			test_done;
		end
		chk(exp_q.size(), 0, "reply missing");
	endtask
	always @(posedge mclk)
		if (tx_valid === 1'b1 && tx_ready === 1'b1)
			if (exp_q.size() == 0)
				chk(1, 0, "extra reply");
			else
				chk(tx_word, exp_q.pop_front(), "reply word");
	initial
	begin
		repeat (6) @(posedge mclk);
		#1 rst_n = 1;
		for (int i = 0; i < 14; i++)
			exch(8'h32, 8'h08, 1, 2, i);
		exch(8'h32, 8'h08, 1, 1, 0);
		exch(8'h32, 8'h08, 1, 0, 0);
		exch(8'h22, 8'h08, 1, 1, 0);
		exch(8'h33, 8'h08, 1, 1, 0);
		exch(8'h32, 8'h05, 1, 1, 0);
		exch(8'h32, 8'h08, 0, 0, 0);
		test_done;
	end
endmodule
